/* mbs_pkg.sv */
// Constants and types for the mode, capture and reply-delay register bank
`default_nettype none
package mbs_pkg;
   // Clock and time bases
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned MS_PER_S         = 1000;
   localparam int unsigned MS_CYC           = CLK_HZ / MS_PER_S;
   localparam int unsigned BASE_RESP_MS     = 5;
   localparam int unsigned BASE_RESP_CYC    = BASE_RESP_MS * MS_CYC;
   localparam int unsigned LOW_PWR_PERIOD_S = 60;
   localparam int unsigned LOW_PWR_PERIOD_CYC = LOW_PWR_PERIOD_S * CLK_HZ;

   // Register numbers on the Modbus side
   localparam logic [15:0] REG_CAPTURE_TAG   = 16'h003b;
   localparam logic [15:0] REG_SNAP_FIRST    = 16'h003c;
   localparam logic [15:0] REG_SNAP_LAST     = 16'h0065;
   localparam logic [15:0] REG_RESP_DELAY    = 16'h00d0;
   localparam logic [15:0] REG_OP_MODE       = 16'h012c;
   localparam logic [15:0] REG_CAPTURE_TRIG  = 16'h012e;
   localparam int unsigned SNAP_WORDS        = 42;

   // Field limits and encodings
   localparam logic [15:0] RESP_DELAY_MAX    = 16'h00fa;
   localparam logic [15:0] MODE_CONTINUOUS   = 16'h0000;
   localparam logic [15:0] MODE_LOW_POWER    = 16'h0001;

   // Values after reset
   localparam logic [15:0] RST_CAPTURE_TAG   = 16'h0000;
   localparam logic [15:0] RST_RESP_DELAY    = 16'h0000;
   localparam logic [15:0] RST_OP_MODE       = 16'h0000;
   localparam logic [15:0] RST_CAPTURE_TRIG  = 16'h0000;
   localparam logic [15:0] RST_SNAP          = 16'h0000;

   typedef enum logic [1:0] {MBS_RSP_IDLE, MBS_RSP_BASE, MBS_RSP_DELAY, MBS_RSP_SEND} mbs_rsp_t;
   typedef enum logic       {MBS_MEAS_OFF, MBS_MEAS_ON} mbs_meas_t;
endpackage
`default_nettype wire

/* mbs_regbank.sv */
// Mode, broadcast capture and reply-delay register bank of the monitor
// Contract
// [R1] Mode 0 keeps the measurement section powered and refreshing continuously.
// [R2] Mode 1 powers measurement once a minute, measures, stores, powers off.
// [R3] Low-power mode keeps the display illumination off.
// [R4] Low-power mode keeps Modbus communication always active.
// [R5] Broadcast write to capture trigger copies live measurements into snapshot words.
// [R6] That capture also copies the written value into the capture tag.
// [R7] Master then reads snapshot and tag from each device in turn.
// [R8] Master should use a fresh trigger value each time and compare tag.
// [R9] Without added delay a reply comes after the base reply time.
// [R10] Reply waits the extra milliseconds held in the response delay register.
// [R11] Default delay setting adds no wait.
// [R12] Response delay accepts 0 to 250 and is read/write.
// [R13] Broadcast writes get no reply but still take effect.
// [R14] Snapshot and tag hold until the next capture.
`timescale 1ns/1ns
`default_nettype none
module mbs_regbank
   import mbs_pkg::*;
#(
   parameter int unsigned P_MS_CYC     = MS_CYC,
   parameter int unsigned P_BASE_CYC   = BASE_RESP_CYC,
   parameter int unsigned P_PERIOD_CYC = LOW_PWR_PERIOD_CYC
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_req_valid,
   input  wire logic                        i_req_write,
   input  wire logic                        i_req_bcast,
   input  wire logic [15:0]                 i_req_addr,
   input  wire logic [15:0]                 i_req_wdata,
   output logic                             o_req_ready,
   output logic                             o_rsp_valid,
   output logic                             o_rsp_err,
   output logic [15:0]                      o_rsp_data,
   input  wire logic [SNAP_WORDS-1:0][15:0] i_live_meas,
   input  wire logic                        i_meas_done,
   output logic                             o_meas_power_en,
   output logic                             o_meas_continuous,
   output logic                             o_meas_start,
   output logic                             o_display_light_en,
   output logic                             o_comm_en,
   output logic                             o_low_power_mode
);
   logic [15:0]                 capture_tag;
   logic [15:0]                 response_delay_ms;
   logic [15:0]                 operating_mode_select;
   logic [15:0]                 capture_trigger;
   logic [SNAP_WORDS-1:0][15:0] snap;
   mbs_rsp_t                    rsp_state;
   mbs_rsp_t                    next_rsp_state;
   mbs_meas_t                   meas_state;
   logic [31:0]                 cyc_cnt;
   logic [7:0]                  ms_left;
   logic [31:0]                 period_cnt;
   logic [31:0]                 elapsed;
   logic [31:0]                 expect_cyc;

   // Request decode
   wire        take       = i_req_valid && (rsp_state == MBS_RSP_IDLE);
   wire        hit_tag    = (i_req_addr == REG_CAPTURE_TAG);
   wire        hit_delay  = (i_req_addr == REG_RESP_DELAY);
   wire        hit_mode   = (i_req_addr == REG_OP_MODE);
   wire        hit_trig   = (i_req_addr == REG_CAPTURE_TRIG);
   wire        hit_snap   = (i_req_addr >= REG_SNAP_FIRST) && (i_req_addr <= REG_SNAP_LAST);
   wire [15:0] snap_off   = i_req_addr - REG_SNAP_FIRST;
   wire [5:0]  snap_idx   = snap_off[5:0];
   wire        wr_delay   = take && i_req_write && hit_delay && (i_req_wdata <= RESP_DELAY_MAX);
   wire        wr_mode    = take && i_req_write && hit_mode && (i_req_wdata <= MODE_LOW_POWER);
   wire        cap_now    = take && i_req_write && hit_trig;
   wire        wr_ok      = hit_trig || (hit_delay && (i_req_wdata <= RESP_DELAY_MAX))
                            || (hit_mode && (i_req_wdata <= MODE_LOW_POWER));
   wire        rd_ok      = hit_tag || hit_delay || hit_mode || hit_trig || hit_snap;
   wire        low_power  = (operating_mode_select == MODE_LOW_POWER);
   wire [15:0] rd_word    = hit_tag   ? capture_tag :
                            hit_delay ? response_delay_ms :
                            hit_mode  ? operating_mode_select :
                            hit_trig  ? capture_trigger :
                            hit_snap  ? snap[snap_idx] : 16'h0000;
   // [R9] Fixed base reply time
   wire        base_done  = (cyc_cnt == P_BASE_CYC - 1);
   wire        ms_done    = (cyc_cnt == P_MS_CYC - 1);

   assign o_req_ready = (rsp_state == MBS_RSP_IDLE);
   assign o_rsp_valid = (rsp_state == MBS_RSP_SEND);

   // [R12] Delay register write
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         response_delay_ms <= RST_RESP_DELAY;
      end else if (wr_delay) begin
         response_delay_ms <= i_req_wdata;
      end
   end

   // [R1] Mode select write
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         operating_mode_select <= RST_OP_MODE;
      end else if (wr_mode) begin
         operating_mode_select <= i_req_wdata;
      end
   end

   // [R6] Trigger value becomes the tag
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         capture_trigger <= RST_CAPTURE_TRIG;
         capture_tag     <= RST_CAPTURE_TAG;
      end else if (cap_now) begin
         capture_trigger <= i_req_wdata;
         capture_tag     <= i_req_wdata;
      end
   end

   // [R5] Freeze every live word at once
   for (genvar g = 0; g < SNAP_WORDS; g++) begin : g_snap
      // [R14] Hold until next capture
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            snap[g] <= RST_SNAP;
         end else if (cap_now) begin
            snap[g] <= i_live_meas[g];
         end
      end
   end

   // Reply sequencer
   always_comb begin
      next_rsp_state = rsp_state;
      case (rsp_state)
         MBS_RSP_IDLE: begin
            // [R13] Broadcasts leave no reply pending
            if (take && !i_req_bcast) begin
               next_rsp_state = MBS_RSP_BASE;
            end
         end
         MBS_RSP_BASE: begin
            // [R11] Zero delay goes straight out
            if (base_done) begin
               next_rsp_state = (ms_left == 8'h00) ? MBS_RSP_SEND : MBS_RSP_DELAY;
            end
         end
         MBS_RSP_DELAY: begin
            if (ms_done && (ms_left == 8'h01)) begin
               next_rsp_state = MBS_RSP_SEND;
            end
         end
         default: begin
            next_rsp_state = MBS_RSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rsp_state <= MBS_RSP_IDLE;
      end else begin
         rsp_state <= next_rsp_state;
      end
   end

   // [R10] Base time then one ms per count
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cyc_cnt <= 32'h0000_0000;
         ms_left <= 8'h00;
      end else if (rsp_state == MBS_RSP_IDLE) begin
         cyc_cnt <= 32'h0000_0000;
         ms_left <= response_delay_ms[7:0];
      end else if ((rsp_state == MBS_RSP_BASE && base_done)
                   || (rsp_state == MBS_RSP_DELAY && ms_done)) begin
         cyc_cnt <= 32'h0000_0000;
         if (rsp_state == MBS_RSP_DELAY) begin
            ms_left <= ms_left - 8'h01;
         end
      end else begin
         cyc_cnt <= cyc_cnt + 32'h0000_0001;
      end
   end

   // Reply word and error flag
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rsp_data <= 16'h0000;
         o_rsp_err  <= 1'b0;
      end else if (take && !i_req_bcast) begin
         o_rsp_data <= i_req_write ? i_req_wdata : rd_word;
         o_rsp_err  <= i_req_write ? !wr_ok : !rd_ok;
      end
   end

   // [R2] Once-a-minute measurement in low-power mode
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meas_state <= MBS_MEAS_OFF;
         period_cnt <= 32'h0000_0000;
      end else if (!low_power) begin
         meas_state <= MBS_MEAS_OFF;
         period_cnt <= 32'h0000_0000;
      end else if (meas_state == MBS_MEAS_OFF) begin
         if (period_cnt == P_PERIOD_CYC - 1) begin
            meas_state <= MBS_MEAS_ON;
            period_cnt <= 32'h0000_0000;
         end else begin
            period_cnt <= period_cnt + 32'h0000_0001;
         end
      end else begin
         period_cnt <= period_cnt + 32'h0000_0001;
         if (i_meas_done) begin
            meas_state <= MBS_MEAS_OFF;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_meas_start <= 1'b0;
      end else begin
         o_meas_start <= low_power && (meas_state == MBS_MEAS_OFF)
                         && (period_cnt == P_PERIOD_CYC - 1);
      end
   end

   // [R1] Continuous power in normal mode
   assign o_meas_power_en    = !low_power || (meas_state == MBS_MEAS_ON);
   assign o_meas_continuous  = !low_power;
   // [R3] Illumination only in normal mode
   assign o_display_light_en = !low_power;
   // [R4] Communication never powered down
   assign o_comm_en          = 1'b1;
   assign o_low_power_mode   = low_power;

   // Cycles since the request was taken
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         elapsed    <= 32'h0000_0000;
         expect_cyc <= 32'h0000_0000;
      end else if (take) begin
         elapsed    <= 32'h0000_0001;
         expect_cyc <= P_BASE_CYC + 32'(response_delay_ms) * P_MS_CYC + 32'd1;
      end else begin
         elapsed    <= elapsed + 32'h0000_0001;
      end
   end

   chk_cont_power_on: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
      !low_power |-> o_meas_power_en && o_meas_continuous)
      else $error("measurement not powered in continuous mode");
   chk_low_power_off: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
      (low_power && meas_state == MBS_MEAS_ON && i_meas_done && !wr_mode)
      |=> !o_meas_power_en)
      else $error("measurement left powered after low-power sample");
   chk_light_off_low: assert property (@(posedge i_clk) disable iff (i_rst) // [R3]
      low_power |-> !o_display_light_en)
      else $error("display lit in low-power mode");
   chk_comm_stays_on: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
      low_power |-> o_comm_en && (rsp_state != MBS_RSP_IDLE || o_req_ready))
      else $error("communication inactive in low-power mode");
   chk_capture_copies: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
      (take && i_req_write && i_req_bcast && hit_trig) |=> (snap == $past(i_live_meas)))
      else $error("snapshot does not match live values");
   chk_tag_follows: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
      (take && i_req_write && i_req_bcast && hit_trig) |=> (capture_tag == $past(i_req_wdata)))
      else $error("capture tag not updated");
   chk_reply_timing: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
      o_rsp_valid |-> (elapsed == expect_cyc))
      else $error("reply time differs from base plus delay");
   chk_delay_in_range: assert property (@(posedge i_clk) disable iff (i_rst) // [R12]
      response_delay_ms <= RESP_DELAY_MAX)
      else $error("response delay above limit");
   chk_bcast_silent: assert property (@(posedge i_clk) disable iff (i_rst) // [R13]
      (take && i_req_bcast) |=> !o_rsp_valid [*2])
      else $error("reply sent to a broadcast");
   chk_snap_holds: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
      !cap_now |=> $stable(snap) && $stable(capture_tag))
      else $error("snapshot changed without capture");
endmodule
`default_nettype wire

/* mbs_master_model.sv */
// Modbus master model: one register request at a time, reply awaited except for broadcasts
`timescale 1ns/1ns
`default_nettype none
module mbs_master_model (
   input  wire logic   i_clk,
   input  wire logic   i_rsp_valid,
   output logic        o_valid,
   output logic        o_write,
   output logic        o_bcast,
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata
);
   initial begin
      o_valid = 1'b0;
      o_write = 1'b0;
      o_bcast = 1'b0;
      o_addr  = 16'h0000;
      o_wdata = 16'h0000;
   end

   task automatic xfer(input logic w, input logic b, input logic [15:0] a,
                       input logic [15:0] d, output int lat);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_write <= w;
      o_bcast <= b;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
      lat = 0;
      // Broadcasts are never answered
      while (!b && i_rsp_valid !== 1'b1 && lat < 2000) begin
         @(posedge i_clk);
         #1;
         lat++;
      end
   endtask
endmodule
`default_nettype wire

/* mbs_regbank_tb.sv */
// Self-checking bench for the mode, capture and reply-delay register bank
`timescale 1ns/1ns
`default_nettype none
module mbs_regbank_tb;
   import mbs_pkg::*;
   localparam int unsigned MS = 3;
   localparam int unsigned BASE = 4;
   localparam int unsigned PER = 20;
   typedef struct {logic w; logic [15:0] a; logic [15:0] d; logic e; logic [15:0] q;} mbs_row_t;
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   logic                        req_valid, req_write, req_bcast, req_ready;
   logic [15:0]                 req_addr, req_wdata, rsp_data;
   logic                        rsp_valid, rsp_err, pwr, cont, start, light, comm, lowp;
   logic [SNAP_WORDS-1:0][15:0] live = '0;
   logic                        meas_done = 1'b0;
   int                          err_total = 0;
   int                          n_compared = 0;
   int                          cyc = 0;
   int                          lat, n;
   logic [15:0]                 dly = 16'h0000;
   // Reads after reset, delay bounds, refused writes, unmapped place
   mbs_row_t rows [17] = '{
      '{1'b0, REG_CAPTURE_TAG, 16'h0000, 1'b0, RST_CAPTURE_TAG},
      '{1'b0, REG_OP_MODE, 16'h0000, 1'b0, RST_OP_MODE},
      '{1'b0, REG_CAPTURE_TRIG, 16'h0000, 1'b0, RST_CAPTURE_TRIG},
      '{1'b0, REG_SNAP_FIRST, 16'h0000, 1'b0, RST_SNAP},
      '{1'b0, REG_RESP_DELAY, 16'h0000, 1'b0, RST_RESP_DELAY},
      '{1'b1, REG_RESP_DELAY, 16'h00fa, 1'b0, 16'h00fa},
      '{1'b0, REG_RESP_DELAY, 16'h0000, 1'b0, 16'h00fa},
      '{1'b1, REG_RESP_DELAY, 16'h00fb, 1'b1, 16'h0000},
      '{1'b0, REG_RESP_DELAY, 16'h0000, 1'b0, 16'h00fa},
      '{1'b1, REG_RESP_DELAY, 16'h0003, 1'b0, 16'h0003},
      '{1'b0, REG_RESP_DELAY, 16'h0000, 1'b0, 16'h0003},
      '{1'b1, REG_OP_MODE, 16'h0002, 1'b1, 16'h0000},
      '{1'b1, REG_CAPTURE_TAG, 16'h0005, 1'b1, 16'h0000},
      '{1'b1, REG_SNAP_FIRST, 16'h0005, 1'b1, 16'h0000},
      '{1'b0, 16'h0100, 16'h0000, 1'b1, 16'h0000},
      '{1'b1, REG_RESP_DELAY, 16'h0000, 1'b0, 16'h0000},
      '{1'b0, REG_OP_MODE, 16'h0000, 1'b0, MODE_CONTINUOUS}};

   always #50 clk = ~clk;

   mbs_regbank #(.P_MS_CYC(MS), .P_BASE_CYC(BASE), .P_PERIOD_CYC(PER)) mbs_regbank_inst (
      .i_clk(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req_write(req_write),
      .i_req_bcast(req_bcast), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
      .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err),
      .o_rsp_data(rsp_data), .i_live_meas(live), .i_meas_done(meas_done),
      .o_meas_power_en(pwr), .o_meas_continuous(cont), .o_meas_start(start),
      .o_display_light_en(light), .o_comm_en(comm), .o_low_power_mode(lowp));

   mbs_master_model mbs_master_model_inst (
      .i_clk(clk), .i_rsp_valid(rsp_valid), .o_valid(req_valid), .o_write(req_write),
      .o_bcast(req_bcast), .o_addr(req_addr), .o_wdata(req_wdata));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      mbs_master_model_inst.xfer(1'b0, 1'b0, a, 16'h0000, lat);
      chk({rsp_err, rsp_data}, {1'b0, exp}, "read data");
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   initial begin
      tick(20);
      chk({req_ready, rsp_valid, pwr, light, comm, cont, lowp}, 7'h5e, "reset outputs");
      rst <= 1'b0;
      foreach (rows[i]) begin
         mbs_master_model_inst.xfer(rows[i].w, 1'b0, rows[i].a, rows[i].d, lat);
         chk(lat, BASE + dly * MS, "reply latency");
         chk(rsp_err, rows[i].e, "error flag");
         if (!rows[i].e) chk(rsp_data, rows[i].q, "reply data");
         if (rows[i].w && !rows[i].e && rows[i].a == REG_RESP_DELAY) dly = rows[i].d;
      end
      // Broadcast capture twice with fresh trigger values
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         for (int i = 0; i < SNAP_WORDS; i++) live[i] <= k ? ~(16'ha000 + 16'(i)) : 16'ha000 + 16'(i);
         mbs_master_model_inst.xfer(1'b1, 1'b1, REG_CAPTURE_TRIG, 16'h1111 << k, lat);
         live <= '0;
         n = 0;
         repeat (BASE * 3) begin
            tick(1);
            n += rsp_valid + !req_ready;
         end
         chk(n, 0, "broadcast reply");
         rdchk(REG_CAPTURE_TAG, 16'h1111 << k);
         rdchk(REG_SNAP_FIRST, k ? 16'h5fff : 16'ha000);
         rdchk(REG_SNAP_LAST, k ? 16'h5fd6 : 16'ha029);
      end
      // Low-power cycle with two samples
      mbs_master_model_inst.xfer(1'b1, 1'b0, REG_OP_MODE, MODE_LOW_POWER, lat);
      chk({lowp, light, comm, cont, pwr}, 5'h14, "low power levels");
      rdchk(REG_OP_MODE, MODE_LOW_POWER);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (start !== 1'b1 && n < 4 * PER) begin
            tick(1);
            n++;
         end
         chk(pwr, 1'b1, "power at start");
         chk(n, k ? PER - 4 : PER - 2 * BASE - 2, "sample period");
         tick(3);
         chk(pwr, 1'b1, "power held");
         meas_done <= 1'b1;
         tick(1);
         meas_done <= 1'b0;
         chk(pwr, 1'b0, "power after done");
      end
      mbs_master_model_inst.xfer(1'b1, 1'b0, REG_OP_MODE, MODE_CONTINUOUS, lat);
      chk({lowp, light, cont, pwr}, 4'h7, "continuous levels");
      print_verdict();
   end
endmodule
`default_nettype wire
